// [channel_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module channel_sync #(
	parameter int WIDTH = 2
) (
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic [WIDTH-1:0] async_in, // Pin levels
	output logic [WIDTH-1:0] sync_out // Synchronised levels
);

	logic [WIDTH-1:0] stage_one;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					stage_one[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					stage_one[i] <= async_in[i];
					sync_out[i] <= stage_one[i];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// [safety_relay_model.sv]
`timescale 1ns/1ps
`default_nettype none

module safety_relay_model #(
	parameter int LAG = 1
) (
	input wire logic pclk, // System clock
	input wire logic [1:0] want_open, // Open request, bit0 ch_a
	output var torque_off_pkg::safety_in_type safety_in // Contacts
);
	logic [1:0] pipe [0:7];

	// Contacts follow the request after LAG cycles
	always_ff @(posedge pclk) begin
		pipe[0] <= ~want_open;
		for (int i = 1; i < 8; i++) begin
			pipe[i] <= pipe[i-1];
		end
	end

	assign safety_in.ch_a = pipe[LAG-1][0];
	assign safety_in.ch_b = pipe[LAG-1][1];
endmodule

`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "torque_off_defines.svh"

module tb_top;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic start_cmd = 0;
	logic stop_cmd = 0;
	logic min_on_hold = 0;
	logic [1:0] want_open = 0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic pslverr;
	logic er;
	logic irq;
	logic [15:0] status_word;
	logic [7:0] trip_code;
	torque_off_pkg::safety_in_type safety_in;
	torque_off_pkg::drive_out_type drive_out;
	torque_off_pkg::display_type display;
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;

	torque_off_supervisor u_dut (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .safety_in(safety_in), .start_cmd(start_cmd),
		.stop_cmd(stop_cmd), .min_on_hold(min_on_hold),
		.drive_out(drive_out), .display(display),
		.status_word(status_word), .trip_code(trip_code), .irq(irq));
	safety_relay_model u_relay (.pclk(pclk), .want_open(want_open),
		.safety_in(safety_in));

	// ----------------------------------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------------------------------
	initial begin
		forever #4 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			summarize();
		end
	end

	task automatic summarize();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic rdchk(input string nm, input logic [11:0] a,
		input logic [31:0] e, input logic ee);
		apb(0, a, 0);
		chk(nm, e, rd);
		chk("pslverr", {31'h0, ee}, {31'h0, er});
	endtask

	task automatic start_run();
		start_cmd <= 1;
		cyc(2);
		start_cmd <= 0;
		cyc(4);
		chk("gate", 1, drive_out.gate_enable);
		chk("brake", 0, drive_out.brake_enable);
	endtask

	task automatic fault_reset();
		apb(1, `OFS_CONTROL, 32'h0000_0051);
		cyc(3);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		rdchk("irq_mask", `OFS_IRQ_MASK, 0, 0);
		rdchk("unmapped", 12'h014, 0, 1);
		apb(1, `OFS_IRQ_STATUS, 32'h0000_0007);
		apb(1, `OFS_IRQ_MASK, 32'h0000_0007);
		apb(1, `OFS_CONTROL, 32'h0000_0350);
		rdchk("irq_mask", `OFS_IRQ_MASK, 7, 0);
		rdchk("control", `OFS_CONTROL, 32'h0000_0350, 0);
		rdchk("status", `OFS_STATUS, 32'h0000_0018, 0);
	endtask

	task automatic t_drop();
		start_run();
		stop_cmd <= 1;
		cyc(3);
		stop_cmd <= 0;
		chk("relay", 1, drive_out.relay_one);
		want_open <= 3;
		cyc(5);
		chk("gate", 0, drive_out.gate_enable);
		chk("status_word", 16'h0020, status_word);
		chk("display", torque_off_pkg::disp_torque_block, display);
		chk("relay", 0, drive_out.relay_one);
		chk("irq", 1, irq);
		want_open <= 0;
		cyc(6);
		chk("status_word", 0, status_word);
		chk("display", torque_off_pkg::disp_normal, display);
		rdchk("irq_status", `OFS_IRQ_STATUS, 5, 0);
		apb(1, `OFS_IRQ_STATUS, 32'h0000_0005);
		rdchk("irq_status", `OFS_IRQ_STATUS, 0, 0);
		chk("irq", 0, irq);
		start_run();
	endtask

	task automatic t_trip();
		want_open <= 3;
		cyc(2);
		want_open <= 0;
		cyc(6);
		chk("trip", 8'h1D, trip_code);
		chk("display", torque_off_pkg::disp_trip, display);
		chk("not_healthy", 1, drive_out.not_healthy);
		chk("gate", 0, drive_out.gate_enable);
		rdchk("fault_code", `OFS_FAULT_CODE, 32'h1D, 0);
		rdchk("status", `OFS_STATUS, 32'h0002_001B, 0);
		cyc(10);
		chk("trip", 8'h1D, trip_code);
		fault_reset();
		chk("trip", 0, trip_code);
		chk("not_healthy", 0, drive_out.not_healthy);
	endtask

	task automatic t_disagree();
		want_open <= 2'b01;
		cyc(5);
		chk("display", torque_off_pkg::disp_torque_block, display);
		chk("status_word", 16'h0020, status_word);
		cyc(20);
		chk("trip", 8'h1D, trip_code);
		chk("not_healthy", 1, drive_out.not_healthy);
		fault_reset();
		chk("trip", 8'h1D, trip_code);
		want_open <= 0;
		cyc(6);
		chk("trip", 8'h1D, trip_code);
		fault_reset();
		chk("trip", 0, trip_code);
	endtask

	task automatic t_override();
		start_run();
		stop_cmd <= 1;
		min_on_hold <= 1;
		cyc(4);
		chk("gate", 1, drive_out.gate_enable);
		want_open <= 3;
		cyc(5);
		chk("gate", 0, drive_out.gate_enable);
		stop_cmd <= 0;
		min_on_hold <= 0;
		want_open <= 0;
		cyc(5);
		fault_reset();
		chk("trip", 0, trip_code);
	endtask

	initial begin
		cyc(2);
		presetn <= 1;
		cyc(2);
		chk("status_word", 16'h0020, status_word);
		chk("relay", 1, drive_out.relay_one);
		chk("gate", 0, drive_out.gate_enable);
		cyc(4);
		t_regs();
		t_drop();
		t_trip();
		t_disagree();
		t_override();
		summarize();
	end
endmodule

`default_nettype wire

// [torque_off_defines.svh]
`ifndef TORQUE_OFF_DEFINES_SVH
`define TORQUE_OFF_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL 12'h000
`define OFS_STATUS 12'h004
`define OFS_IRQ_STATUS 12'h008
`define OFS_IRQ_MASK 12'h00C
`define OFS_FAULT_CODE 12'h010

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTL_FAULT_RESET 0
`define CTL_RELAY_SEL_LSB 4
`define CTL_CMD_SRC_LSB 8
`define STAT_WORD_TORQUE_OFF 5
`define IRQ_ACTIVATE 0
`define IRQ_FAULT 1
`define IRQ_RELEASE 2

// ----------------------------------------------------------------
// Values and reset values
// ----------------------------------------------------------------
`define RELAY_SEL_TORQUE_OFF 4'h5
`define FAULT_CODE_CHANNEL 8'h1D
`define RELAY_SEL_RESET 4'h0
`define CMD_SRC_RESET 3'h0
`define IRQ_MASK_RESET 3'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_PS 8000
`define TORQUE_OFF_LIMIT_NS 1000
`define MONITOR_LIMIT_NS 20000000
`define TORQUE_OFF_LIMIT_CYCLES (`TORQUE_OFF_LIMIT_NS * 1000 / `CLK_PERIOD_PS)
`define MONITOR_LIMIT_CYCLES (`MONITOR_LIMIT_NS / 1000 * 1000 / `CLK_PERIOD_PS)
`define DISAGREE_CYCLES 16
`define RESPONSE_EDGES 3

`endif

// [torque_off_pkg.sv]
`default_nettype none

package torque_off_pkg;

	typedef enum logic [1:0] {
		st_standby = 2'b00,
		st_torque_off = 2'b01,
		st_faulted = 2'b10
	} sup_state_type;

	typedef enum logic [1:0] {
		disp_normal = 2'b00,
		disp_torque_block = 2'b01,
		disp_trip = 2'b10
	} display_type;

	typedef struct packed {
		logic ch_a;
		logic ch_b;
	} safety_in_type;

	typedef struct packed {
		logic gate_enable;
		logic brake_enable;
		logic relay_one;
		logic not_healthy;
	} drive_out_type;

endpackage

`default_nettype wire

// [torque_off_supervisor.sv]
// Operation
// - Energised input: standby, start runs normally
// - De-energised: remove drive, coast, enter off
// - Leave only with faults reset and energised; off state leaves on energised alone, no fault reset needed
// - Re-energised restart not blocked here
// - Active: keypad torque block, status bit 5
// - Tripped keypad shows trip instead
// - Relay select 5 opens relay one
// - Channel fault raises trip code 29
// - Momentary opening while running trips
// - No torque within 1 us
// - Monitoring status within 20 ms
// - Fault display and not-healthy within 20 ms
// - Never apply motor braking
// - Safety input overrides all commands
`timescale 1ns/1ps
`default_nettype none
`include "torque_off_defines.svh"

module torque_off_supervisor (
	input wire logic pclk, // System clock, 125 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic [11:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire torque_off_pkg::safety_in_type safety_in, // Safety pins
	input wire logic start_cmd, // Start from command source
	input wire logic stop_cmd, // Stop from command source
	input wire logic min_on_hold, // Minimum on time still running
	output torque_off_pkg::drive_out_type drive_out, // Power stage
	output torque_off_pkg::display_type display, // Keypad indication
	output logic [15:0] status_word, // Drive status word
	output logic [7:0] trip_code, // Active trip code
	output logic irq // Interrupt level
);

	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------
	logic [1:0] chan_sync;
	logic [1:0] chan_prev;
	logic [4:0] disagree_count;

	channel_sync #(.WIDTH(2)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({safety_in.ch_a, safety_in.ch_b}),
		.sync_out(chan_sync)
	);

	wire energised = &chan_sync;
	wire channels_differ = chan_sync[1] ^ chan_sync[0];
	wire channel_fault = disagree_count == 5'(`DISAGREE_CYCLES);
	wire dropped = (&chan_prev) && !energised;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	torque_off_pkg::sup_state_type state;
	torque_off_pkg::sup_state_type next_state;
	logic running;
	logic trip_latched;
	logic [3:0] relay_sel;
	logic [2:0] cmd_src;
	logic [2:0] irq_status;
	logic [2:0] irq_mask;

	wire apb_write = psel && penable && pwrite;
	wire hit_control = paddr == `OFS_CONTROL;
	wire hit_status = paddr == `OFS_STATUS;
	wire hit_irq_status = paddr == `OFS_IRQ_STATUS;
	wire hit_irq_mask = paddr == `OFS_IRQ_MASK;
	wire hit_fault = paddr == `OFS_FAULT_CODE;
	wire mapped = hit_control || hit_status || hit_irq_status ||
		hit_irq_mask || hit_fault;
	wire wr_control = apb_write && hit_control;
	wire fault_reset = wr_control && pwdata[`CTL_FAULT_RESET];
	wire tripping = channel_fault || (dropped && running);
	wire active = state != torque_off_pkg::st_standby;

	// ----------------------------------------------------------------
	// Supervisor state machine
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			torque_off_pkg::st_standby: begin
				if (tripping)
					next_state = torque_off_pkg::st_faulted;
				else if (!energised)
					next_state = torque_off_pkg::st_torque_off;
			end
			torque_off_pkg::st_torque_off: begin
				if (channel_fault)
					next_state = torque_off_pkg::st_faulted;
				else if (energised)
					next_state = torque_off_pkg::st_standby;
			end
			torque_off_pkg::st_faulted: begin
				if (fault_reset && energised && !channel_fault)
					next_state = torque_off_pkg::st_standby;
			end
			default: next_state = torque_off_pkg::st_faulted;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= torque_off_pkg::st_torque_off;
			// Low previous sample keeps reset release from reading as a drop
			chan_prev <= 2'h0;
			disagree_count <= 5'h00;
		end else begin
			state <= next_state;
			chan_prev <= chan_sync;
			// Counter saturates so a lasting mismatch holds the fault
			if (!channels_differ)
				disagree_count <= 5'h00;
			else if (!channel_fault)
				disagree_count <= disagree_count + 5'h01;
		end
	end

	// ----------------------------------------------------------------
	// Run latch
	// ----------------------------------------------------------------
	// Start is honoured only in standby; no torque hold outlasts the input
	wire next_running = energised && state == torque_off_pkg::st_standby &&
		!tripping && (start_cmd || (running && (!stop_cmd || min_on_hold)));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			running <= 1'b0;
		else
			running <= next_running;
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	wire [2:0] irq_events = {
		state == torque_off_pkg::st_torque_off && energised,
		tripping && !trip_latched,
		dropped
	};
	wire [2:0] irq_clear = (apb_write && hit_irq_status) ? pwdata[2:0] :
		3'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			relay_sel <= `RELAY_SEL_RESET;
			cmd_src <= `CMD_SRC_RESET;
			irq_mask <= `IRQ_MASK_RESET;
			irq_status <= 3'h0;
			trip_latched <= 1'b0;
		end else begin
			if (wr_control) begin
				relay_sel <= pwdata[`CTL_RELAY_SEL_LSB +: 4];
				cmd_src <= pwdata[`CTL_CMD_SRC_LSB +: 3];
			end
			if (apb_write && hit_irq_mask)
				irq_mask <= pwdata[2:0];
			// An event in the clear cycle wins over the clear
			irq_status <= (irq_status & ~irq_clear) | irq_events;
			trip_latched <= next_state == torque_off_pkg::st_faulted;
		end
	end

	// ----------------------------------------------------------------
	// APB read path
	// ----------------------------------------------------------------
	wire [31:0] rd_mux =
		hit_control ? {21'h0, cmd_src, relay_sel, 4'h0} :
		hit_status ? {14'h0, state, 11'h0, chan_sync, running, active,
			trip_latched} :
		hit_irq_status ? {29'h0, irq_status} :
		hit_irq_mask ? {29'h0, irq_mask} :
		hit_fault ? {24'h0, trip_latched ? `FAULT_CODE_CHANNEL : 8'h00} :
		32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// Zero wait states: the answer stands in the access cycle
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	wire faulted_next = next_state == torque_off_pkg::st_faulted;
	wire active_next = next_state != torque_off_pkg::st_standby;
	wire [15:0] next_status = 16'(active_next) << `STAT_WORD_TORQUE_OFF;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_out <= '0;
			display <= torque_off_pkg::disp_torque_block;
			status_word <= 16'h0020;
			trip_code <= 8'h00;
			irq <= 1'b0;
		end else begin
			drive_out.gate_enable <= next_running;
			drive_out.brake_enable <= 1'b0;
			drive_out.relay_one <= !(relay_sel ==
				`RELAY_SEL_TORQUE_OFF && active_next);
			drive_out.not_healthy <= faulted_next;
			if (faulted_next)
				display <= torque_off_pkg::disp_trip;
			else if (active_next)
				display <= torque_off_pkg::disp_torque_block;
			else
				display <= torque_off_pkg::disp_normal;
			status_word <= next_status;
			trip_code <= faulted_next ? `FAULT_CODE_CHANNEL : 8'h00;
			irq <= |(((irq_status & ~irq_clear) | irq_events) & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Outputs are registered from next_state, so they track state at once
	localparam int TORQUE_BOUND = `RESPONSE_EDGES;

	torque_removed_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!energised |-> ##[1:TORQUE_BOUND] !drive_out.gate_enable)
		else $error("drive still enabled after input drop");

	no_brake_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!drive_out.brake_enable)
		else $error("brake applied");

	status_bit_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		status_word == (16'(active) << `STAT_WORD_TORQUE_OFF))
		else $error("status bit 5 disagrees with state");

	trip_display_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		state == torque_off_pkg::st_faulted |->
		display == torque_off_pkg::disp_trip)
		else $error("trip not shown on keypad");

	relay_open_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(active && relay_sel == 4'h5 && $stable(relay_sel)) |->
		!drive_out.relay_one)
		else $error("relay one closed while active");

	fault_trip_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		channel_fault |=> trip_code == 8'h1D && drive_out.not_healthy)
		else $error("channel fault without trip 29");

	blip_trip_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(running && dropped) |=> state == torque_off_pkg::st_faulted)
		else $error("opening while running did not trip");

	release_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(state == torque_off_pkg::st_faulted && !fault_reset) |=>
		state == torque_off_pkg::st_faulted)
		else $error("fault left without reset");

	either_chan_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$fell(energised) |=> state != torque_off_pkg::st_standby)
		else $error("single channel drop ignored");

	override_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(min_on_hold && !energised) |=> !running)
		else $error("minimum on time kept drive running");

	start_run_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(state == torque_off_pkg::st_standby && energised && start_cmd &&
		!tripping) |=> drive_out.gate_enable)
		else $error("start ignored in standby");

	coast_stop_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		active |-> !drive_out.gate_enable)
		else $error("power stage on while torque off active");

	restart_free_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(state == torque_off_pkg::st_torque_off && energised &&
		!channel_fault) |=> state == torque_off_pkg::st_standby)
		else $error("restart blocked after input returned");

	keypad_block_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		state == torque_off_pkg::st_torque_off |->
		display == torque_off_pkg::disp_torque_block)
		else $error("torque block not shown on keypad");

	monitor_status_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$fell(energised) |-> ##[1:TORQUE_BOUND] status_word[5])
		else $error("status word late after input drop");

	unhealthy_out_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		state == torque_off_pkg::st_faulted |->
		drive_out.not_healthy && trip_code == `FAULT_CODE_CHANNEL)
		else $error("fault not reported as not healthy");

	single_chan_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		channels_differ |=> state != torque_off_pkg::st_standby)
		else $error("channel mismatch left drive in standby");

	relay_closed_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		relay_sel != `RELAY_SEL_TORQUE_OFF |=> drive_out.relay_one)
		else $error("relay one opened with other function");

	irq_level_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!$changed(irq_mask) |-> irq == |(irq_status & irq_mask))
		else $error("interrupt level disagrees with status");

	pready_pulse_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held past one cycle");

endmodule

`default_nettype wire
